// *** design/probe_capture_pkg.sv ***
package probe_capture_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_CFG    = 8'h04;
  localparam logic [7:0] OFF_WIN_LO = 8'h08;
  localparam logic [7:0] OFF_WIN_HI = 8'h0c;
  localparam logic [7:0] OFF_HLIM   = 8'h10;
  localparam logic [7:0] OFF_STAT   = 8'h14;
  localparam logic [7:0] OFF_FAULT  = 8'h18;
  localparam logic [7:0] OFF_CAP0   = 8'h1c;
  localparam logic [7:0] OFF_CAP1   = 8'h20;
  localparam logic [7:0] OFF_POS    = 8'h24;
  // Control, config and status field positions
  localparam int CTRL_START = 0;
  localparam int CTRL_ABORT = 1;
  localparam int CTRL_SEL   = 2;
  localparam int CTRL_WIN   = 4;
  localparam int CTRL_ROT   = 5;
  localparam int CFG_FALL   = 0;
  localparam int CFG_REMOTE = 2;
  localparam int STAT_SLOT  = 8;
  localparam int STAT_WARN  = 16;
  localparam int STAT_ERR   = 17;
  // Reset values
  localparam logic [31:0] RST_HLIM = 32'h0001_0000;
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;
  // Fault codes
  localparam logic [15:0] FC_NONE    = 16'h0000;
  localparam logic [15:0] FC_BAD_SEL = 16'h0001;
  localparam logic [15:0] FC_NO_ENC  = 16'h0002;
  localparam logic [15:0] FC_BAD_WIN = 16'h0003;
  // Timing
  localparam int CLK_NS       = 8;
  localparam int PULSE_MIN_NS = 3000;
  localparam int FILTER_NS    = 2000;
  localparam int FILT_CYC     = FILTER_NS / CLK_NS;
  localparam logic [1:0] RESP_OK  = 2'b00;
  localparam logic [1:0] RESP_ERR = 2'b10;
  typedef enum logic {SLOT_IDLE, SLOT_ARMED} slot_state_t;
endpackage

// *** design/axis_probe_position_capture.sv ***
// Summary of operation
// - Two independent probe inputs per axis, each with its own capture slot.
// - Each probe routes from a panel input or a remote terminal input.
// - Each probe fires on rising or falling edge only, per configuration.
// - Probe pulses last at least 3 us; the filter passes such pulses.
// - Filtered edge latches position within one count, latency under 10 us.
// - Arm only on a rising edge of start; a held start does nothing.
// - Probe select 1 means first probe, 2 means second probe.
// - One arming records one event; re-arm for any further event.
// - Arming an armed slot cancels the old capture and flags it aborted.
// - Abort command ends armed captures without recording a position.
// - An armed slot stays armed until its event is accepted or aborted.
// - Arming clears the captured position to zero.
// - Window off: first qualifying edge is accepted at any position.
// - Window on: accept only inside the window, otherwise stay armed.
// - Both window bounds are inclusive.
// - Signed compare, positive is larger; direction of entry is irrelevant.
// - Rotary axis wraps at the high limit; window uses wrapped position.
// - Done rises when a position is latched; value shown in capture register.
// - Busy from arming until capture or abort; a failed arm leaves busy unchanged.
// - Separate error and warning flags with a 16-bit fault code.
// - Virtual axis yields valid captures only with an external encoder.
`timescale 1ns/1ns
`default_nettype none
module axis_probe_position_capture
  import probe_capture_pkg::*;
(
  input  wire logic        aclk,          // System clock
  input  wire logic        aresetn,       // Sync reset, active low
  input  wire logic [7:0]  s_axi_awaddr,  // Write address
  input  wire logic        s_axi_awvalid, // Write address valid
  output logic             s_axi_awready, // Write address ready
  input  wire logic [31:0] s_axi_wdata,   // Write data
  input  wire logic [3:0]  s_axi_wstrb,   // Byte strobes
  input  wire logic        s_axi_wvalid,  // Write data valid
  output logic             s_axi_wready,  // Write data ready
  output logic [1:0]       s_axi_bresp,   // Write response
  output logic             s_axi_bvalid,  // Write response valid
  input  wire logic        s_axi_bready,  // Write response ready
  input  wire logic [7:0]  s_axi_araddr,  // Read address
  input  wire logic        s_axi_arvalid, // Read address valid
  output logic             s_axi_arready, // Read address ready
  output logic [31:0]      s_axi_rdata,   // Read data
  output logic [1:0]       s_axi_rresp,   // Read response
  output logic             s_axi_rvalid,  // Read data valid
  input  wire logic        s_axi_rready,  // Read data ready
  input  wire logic [31:0] axis_position, // Actual position, signed counts
  input  wire logic        virtual_axis,  // Axis has no own feedback
  input  wire logic        ext_encoder,   // External encoder present
  input  wire logic [1:0]  panel_in,      // Panel digital inputs per probe
  input  wire logic [1:0]  remote_in      // Remote terminal inputs per probe
);

  logic [31:0] ctrl_q, cfg_q, win_lo_q, win_hi_q, hlim_q, pos_w_q;
  logic [31:0] cap_q [2], evt_pos_q [2];
  logic [15:0] fault_q;
  logic        warn_q, err_q, start_prev_q, abort_prev_q, aw_got_q, w_got_q;
  logic [7:0]  awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  slot_state_t st_q [2];
  logic [1:0]  busy_q, done_q, abrt_q, filt_q, evt_q, win_on_q, raw, arm, sel;
  logic        start_rise, abort_rise, sel_ok, arm_fail, arm_warn;

  // Byte-lane merge of a write into a register
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (be[i]) r[8*i +: 8] = nw[8*i +: 8];
    return r;
  endfunction

  // Inclusive window test, signed; wraps through rollover on rotary axes
  function automatic logic in_window(input logic [31:0] p, input logic [31:0] lo,
                                     input logic [31:0] hi, input logic rot);
    if ($signed(lo) <= $signed(hi)) return $signed(p) >= $signed(lo) && $signed(p) <= $signed(hi);
    return rot && ($signed(p) >= $signed(lo) || $signed(p) <= $signed(hi));
  endfunction

  // Command decode from the control register
  assign sel        = ctrl_q[CTRL_SEL +: 2];
  assign start_rise = ctrl_q[CTRL_START] && !start_prev_q;
  assign abort_rise = ctrl_q[CTRL_ABORT] && !abort_prev_q;
  assign sel_ok     = (sel == 2'd1) || (sel == 2'd2);
  assign arm_fail   = start_rise && (!sel_ok || (virtual_axis && !ext_encoder));
  assign arm_warn   = ctrl_q[CTRL_WIN] && !ctrl_q[CTRL_ROT]
                      && ($signed(win_lo_q) > $signed(win_hi_q));
  assign arm[0]     = start_rise && !arm_fail && (sel == 2'd1);
  assign arm[1]     = start_rise && !arm_fail && (sel == 2'd2);

  // AXI write address and data capture, either order
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_got_q <= 1'b0;
      w_got_q  <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q  <= RST_ZERO;
      wstrb_q  <= 4'h0;
    end
    else if (aw_got_q && w_got_q)
    begin
      aw_got_q <= 1'b0;
      w_got_q  <= 1'b0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_got_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_got_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
    end
  end

  // Ready and response flops for the write path
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OK;
    end
    else
    begin
      s_axi_awready <= !aw_got_q && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
      s_axi_wready  <= !w_got_q && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
      if (aw_got_q && w_got_q)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (awaddr_q[1:0] == 2'b00 && awaddr_q <= OFF_HLIM) ? RESP_OK : RESP_ERR;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // Writable registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_q   <= RST_ZERO;
      cfg_q    <= RST_ZERO;
      win_lo_q <= RST_ZERO;
      win_hi_q <= RST_ZERO;
      hlim_q   <= RST_HLIM;
    end
    else if (aw_got_q && w_got_q)
    begin
      case (awaddr_q)
        OFF_CTRL:   ctrl_q   <= merge(ctrl_q, wdata_q, wstrb_q);
        OFF_CFG:    cfg_q    <= merge(cfg_q, wdata_q, wstrb_q);
        OFF_WIN_LO: win_lo_q <= merge(win_lo_q, wdata_q, wstrb_q);
        OFF_WIN_HI: win_hi_q <= merge(win_hi_q, wdata_q, wstrb_q);
        OFF_HLIM:   hlim_q   <= merge(hlim_q, wdata_q, wstrb_q);
        default:    ;
      endcase
    end
  end

  // AXI read path
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= RST_ZERO;
      s_axi_rresp   <= RESP_OK;
    end
    else
    begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= RESP_OK;
        case (s_axi_araddr)
          OFF_CTRL:   s_axi_rdata <= ctrl_q;
          OFF_CFG:    s_axi_rdata <= cfg_q;
          OFF_WIN_LO: s_axi_rdata <= win_lo_q;
          OFF_WIN_HI: s_axi_rdata <= win_hi_q;
          OFF_HLIM:   s_axi_rdata <= hlim_q;
          OFF_STAT:   s_axi_rdata <= {14'h0, err_q, warn_q, 5'h0, abrt_q[1], done_q[1], busy_q[1],
                                      5'h0, abrt_q[0], done_q[0], busy_q[0]};
          OFF_FAULT:  s_axi_rdata <= {16'h0, fault_q};
          OFF_CAP0:   s_axi_rdata <= cap_q[0];
          OFF_CAP1:   s_axi_rdata <= cap_q[1];
          OFF_POS:    s_axi_rdata <= pos_w_q;
          default:
          begin
            s_axi_rdata <= RST_ZERO;
            s_axi_rresp <= RESP_ERR;
          end
        endcase
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // Command edge history
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      {abort_prev_q, start_prev_q} <= 2'b00;
    else
      {abort_prev_q, start_prev_q} <= {ctrl_q[CTRL_ABORT], ctrl_q[CTRL_START]};
  end

  // Rotary wrap of the actual position into 0 .. limit-1
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      pos_w_q <= RST_ZERO;
    else if (ctrl_q[CTRL_ROT] && $signed(axis_position) < 0)
      pos_w_q <= axis_position + hlim_q;
    else if (ctrl_q[CTRL_ROT] && $signed(axis_position) >= $signed(hlim_q))
      pos_w_q <= axis_position - hlim_q;
    else
      pos_w_q <= axis_position;
  end

  // Error and warning flags with fault code, updated per arm attempt
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      err_q   <= 1'b0;
      warn_q  <= 1'b0;
      fault_q <= FC_NONE;
    end
    else if (start_rise)
    begin
      err_q   <= arm_fail;
      warn_q  <= !arm_fail && arm_warn;
      if (!sel_ok)
        fault_q <= FC_BAD_SEL;
      else if (arm_fail)
        fault_q <= FC_NO_ENC;
      else if (arm_warn)
        fault_q <= FC_BAD_WIN;
      else
        fault_q <= FC_NONE;
    end
  end

  // Per-probe filter, edge detect and capture slot
  for (genvar k = 0; k < 2; k++)
  begin : g_probe
    logic [8:0] cnt_q;
    logic       ok;
    assign raw[k] = cfg_q[CFG_REMOTE + k] ? remote_in[k] : panel_in[k];
    assign ok     = !win_on_q[k] || in_window(evt_pos_q[k], win_lo_q, win_hi_q, ctrl_q[CTRL_ROT]);
    // Input filter: level must hold FILT_CYC cycles before it counts
    always_ff @(posedge aclk)
    begin
      if (!aresetn)
      begin
        cnt_q     <= 9'h000;
        filt_q[k] <= 1'b0;
        evt_q[k]  <= 1'b0;
        evt_pos_q[k] <= RST_ZERO;
      end
      else
      begin
        evt_q[k] <= 1'b0;
        if (raw[k] == filt_q[k])
          cnt_q <= 9'h000;
        else if (cnt_q == 9'(FILT_CYC - 1))
        begin
          cnt_q     <= 9'h000;
          filt_q[k] <= raw[k];
          evt_q[k]  <= raw[k] != cfg_q[CFG_FALL + k];
          evt_pos_q[k] <= pos_w_q;
        end
        else
          cnt_q <= cnt_q + 9'h001;
      end
    end
    // Capture slot state and flags
    always_ff @(posedge aclk)
    begin
      if (!aresetn)
      begin
        st_q[k]     <= SLOT_IDLE;
        busy_q[k]   <= 1'b0;
        done_q[k]   <= 1'b0;
        abrt_q[k]   <= 1'b0;
        win_on_q[k] <= 1'b0;
        cap_q[k]    <= RST_ZERO;
      end
      else if (arm[k])
      begin
        st_q[k]     <= SLOT_ARMED;
        busy_q[k]   <= 1'b1;
        done_q[k]   <= 1'b0;
        abrt_q[k]   <= st_q[k] == SLOT_ARMED;
        win_on_q[k] <= ctrl_q[CTRL_WIN];
        cap_q[k]    <= RST_ZERO;
      end
      else
      begin
        case (st_q[k])
          SLOT_ARMED:
          begin
            if (abort_rise)
            begin
              st_q[k]   <= SLOT_IDLE;
              busy_q[k] <= 1'b0;
              abrt_q[k] <= 1'b1;
            end
            else if (evt_q[k] && ok)
            begin
              st_q[k]   <= SLOT_IDLE;
              busy_q[k] <= 1'b0;
              done_q[k] <= 1'b1;
              cap_q[k]  <= evt_pos_q[k];
            end
          end
          default: ;
        endcase
      end
    end
  end

  // Checks on slot 0, the position path and arm failures; abort cover on slot 1
  property p_arm_clear;
    @(posedge aclk) disable iff (!aresetn) arm[0] |=> busy_q[0] && !done_q[0] && cap_q[0] == 32'h0000_0000;
  endproperty
  a_arm_clear: assert property (p_arm_clear) else $error("arm did not clear capture");
  property p_held_start;
    @(posedge aclk) disable iff (!aresetn) ctrl_q[CTRL_START] && $past(ctrl_q[CTRL_START]) |-> arm == 2'b00;
  endproperty
  a_held_start: assert property (p_held_start) else $error("held start re-armed");
  property p_capture;
    @(posedge aclk) disable iff (!aresetn) busy_q[0] && evt_q[0] && g_probe[0].ok && !abort_rise && !arm[0]
      |=> done_q[0] && !busy_q[0] && cap_q[0] == $past(evt_pos_q[0]);
  endproperty
  a_capture: assert property (p_capture) else $error("event not captured");
  property p_outside;
    @(posedge aclk) disable iff (!aresetn)
    busy_q[0] && evt_q[0] && !g_probe[0].ok && !abort_rise && !arm[0] |=> busy_q[0] && !done_q[0];
  endproperty
  a_outside: assert property (p_outside) else $error("outside edge accepted");
  property p_abort;
    @(posedge aclk) disable iff (!aresetn)
    busy_q[0] && abort_rise && !arm[0] |=> !busy_q[0] && abrt_q[0] && $stable(cap_q[0]);
  endproperty
  a_abort: assert property (p_abort) else $error("abort failed");
  property p_rearm;
    @(posedge aclk) disable iff (!aresetn) busy_q[0] && arm[0] |=> busy_q[0] && abrt_q[0];
  endproperty
  a_rearm: assert property (p_rearm) else $error("re-arm not flagged");
  property p_single;
    @(posedge aclk) disable iff (!aresetn) done_q[0] && !busy_q[0] && !arm[0] |=> !busy_q[0] && $stable(cap_q[0]);
  endproperty
  a_single: assert property (p_single) else $error("second event recorded");
  property p_edge;
    @(posedge aclk) disable iff (!aresetn) evt_q[0] |-> filt_q[0] != cfg_q[CFG_FALL];
  endproperty
  a_edge: assert property (p_edge) else $error("wrong edge fired");
  property p_wrap;
    @(posedge aclk) disable iff (!aresetn)
    ctrl_q[CTRL_ROT] && $signed(axis_position) < 0 |=> pos_w_q == $past(axis_position) + $past(hlim_q);
  endproperty
  a_wrap: assert property (p_wrap) else $error("negative wrap wrong");
  property p_fail;
    @(posedge aclk) disable iff (!aresetn) arm_fail |=> err_q && fault_q != 16'h0000 ##1 err_q;
  endproperty
  a_fail: assert property (p_fail) else $error("failure not reported");
  property p_cv_cap;
    @(posedge aclk) disable iff (!aresetn) busy_q[0] ##1 done_q[0];
  endproperty
  c_cv_cap: cover property (p_cv_cap);
  property p_cv_abort;
    @(posedge aclk) disable iff (!aresetn) busy_q[1] && abort_rise;
  endproperty
  c_cv_abort: cover property (p_cv_abort);
  property p_cv_rearm;
    @(posedge aclk) disable iff (!aresetn) busy_q[0] && arm[0];
  endproperty
  c_cv_rearm: cover property (p_cv_rearm);
endmodule // axis_probe_position_capture
`default_nettype wire

// *** test/probe_sensor.sv ***
`timescale 1ns/1ns
`default_nettype none
module probe_sensor
  import probe_capture_pkg::*;
(
  input  wire logic       aclk,     // System clock
  output logic      [1:0] panel_in, // Panel probe lines
  output logic      [1:0] remote_in // Remote terminal probe lines
);
  localparam int PULSE_CYC = PULSE_MIN_NS / CLK_NS;
  // Lines rest low until a pulse gives them an idle level
  initial
  begin
    panel_in  = 2'h0;
    remote_in = 2'h0;
  end
  // Settle at idle, hold the active level, then rest at idle again
  task automatic pulse(input int idx, input logic rem, input logic lvl, input int cyc);
    if (cyc < PULSE_CYC)
      cyc = PULSE_CYC;
    for (int ph = 0; ph < 3; ph++)
    begin
      if (rem)
        remote_in[idx] <= (ph == 1) ? lvl : ~lvl;
      else
        panel_in[idx] <= (ph == 1) ? lvl : ~lvl;
      repeat ((ph == 1) ? cyc : 300) @(posedge aclk);
    end
  endtask
endmodule // probe_sensor
`default_nettype wire

// *** test/axis_probe_position_capture_tb_top.sv ***
`timescale 1ns/1ns
`default_nettype none
module axis_probe_position_capture_tb_top
  import probe_capture_pkg::*;
();
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [31:0] pos = 32'h0;
  logic [31:0] rdata;
  logic [3:0]  wstrb = 4'hf;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, resp, panel_in, remote_in;
  logic        virt = 1'b0, enc = 1'b0;
  int          fails = 0, n_compared = 0, cycles = 0;

  // Clock and hang guard
  always #4 aclk = ~aclk;
  always @(posedge aclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 40000)
    begin
      fails = fails + 1;
      report_and_stop();
    end
  end

  axis_probe_position_capture DUT (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .axis_position(pos),
    .virtual_axis(virt), .ext_encoder(enc), .panel_in(panel_in), .remote_in(remote_in));

  probe_sensor u_probe (.aclk(aclk), .panel_in(panel_in), .remote_in(remote_in));

  task automatic report_and_stop();
    $display("Compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp)
    begin
      fails++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // Bus write: offer both channels, release each when taken, wait for response
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
    end while (!bvalid);
    resp = bresp;
    bready <= 1'b0;
    @(posedge aclk);
  endtask

  // Bus read and compare under a mask
  task automatic rc(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m = 32'hffffffff);
    logic [31:0] d;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arvalid && arready)
        arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    resp = rresp;
    rready <= 1'b0;
    @(posedge aclk);
    chk(d & m, exp, $sformatf("read %h", a));
  endtask

  // Start goes low then high so that each call is one rising edge
  task automatic arm(input logic [31:0] v);
    wr(OFF_CTRL, v & 32'hfffffffe);
    wr(OFF_CTRL, v | 32'h1);
  endtask

  task automatic t_reset();
    rc(OFF_HLIM, RST_HLIM);
    rc(OFF_STAT, RST_ZERO);
    rc(8'h30, RST_ZERO);
    chk({30'h0, resp}, {30'h0, RESP_ERR}, "unmapped read");
    wr(OFF_STAT, 32'hffffffff);
    chk({30'h0, resp}, {30'h0, RESP_ERR}, "read-only write");
    rc(OFF_STAT, RST_ZERO);
    wr(OFF_HLIM, 32'hffffffff, 4'h1);
    rc(OFF_HLIM, 32'h000100ff);
    wr(OFF_HLIM, RST_HLIM);
  endtask

  task automatic t_basic();
    pos <= 32'd1234;
    arm(32'h4);
    rc(OFF_STAT, 32'h1);
    u_probe.pulse(0, 1'b0, 1'b1, 375);
    rc(OFF_STAT, 32'h2);
    rc(OFF_CAP0, 32'd1234);
    wr(OFF_CTRL, 32'h5);
    pos <= 32'd5555;
    u_probe.pulse(0, 1'b0, 1'b1, 375);
    rc(OFF_STAT, 32'h2);
    rc(OFF_CAP0, 32'd1234);
    arm(32'h4);
    rc(OFF_CAP0, 32'h0);
    arm(32'h4);
    rc(OFF_STAT, 32'h5);
    wr(OFF_CTRL, 32'h2);
    wr(OFF_CTRL, 32'h0);
    rc(OFF_STAT, 32'h4);
    u_probe.pulse(0, 1'b0, 1'b1, 375);
    rc(OFF_CAP0, 32'h0);
  endtask

  // Falling edge only: position moves between the two edges of the pulse
  task automatic t_fall();
    wr(OFF_CFG, 32'h1);
    pos <= 32'd1111;
    arm(32'h4);
    fork
      u_probe.pulse(0, 1'b0, 1'b1, 375);
      begin
        repeat (610) @(posedge aclk);
        pos <= 32'd2222;
      end
    join
    rc(OFF_STAT, 32'h2);
    rc(OFF_CAP0, 32'd2222);
  endtask

  // Second probe on the remote line, falling edge, with a decoy on the panel line;
  // then an abort of the second slot and the first probe on its remote line
  task automatic t_remote();
    wr(OFF_CFG, 32'ha);
    pos <= 32'd777;
    arm(32'h8);
    rc(OFF_STAT, 32'h102);
    u_probe.pulse(1, 1'b0, 1'b0, 375);
    rc(OFF_STAT, 32'h102);
    u_probe.pulse(1, 1'b1, 1'b0, 375);
    rc(OFF_STAT, 32'h202);
    rc(OFF_CAP1, 32'd777);
    arm(32'h8);
    wr(OFF_CTRL, 32'ha);
    rc(OFF_STAT, 32'h402);
    wr(OFF_CFG, 32'h4);
    pos <= 32'd888;
    arm(32'h4);
    u_probe.pulse(0, 1'b0, 1'b1, 375);
    rc(OFF_STAT, 32'h401);
    u_probe.pulse(0, 1'b1, 1'b1, 375);
    rc(OFF_CAP0, 32'd888);
  endtask

  // Inclusive linear window, then rotary window through the rollover
  task automatic t_window();
    int tp [7] = '{99, 100, 201, 200, 30000, 70000, -1000};
    int wp [7] = '{99, 100, 201, 200, 30000, 4464, 64536};
    wr(OFF_CFG, 32'h0);
    wr(OFF_WIN_LO, 32'd100);
    wr(OFF_WIN_HI, 32'd200);
    for (int i = 0; i < 7; i++)
    begin
      if (i == 4)
      begin
        wr(OFF_WIN_LO, 32'd60000);
        wr(OFF_WIN_HI, 32'd5000);
      end
      if (i == 0 || i == 2 || i == 4 || i == 6)
        arm((i < 4) ? 32'h14 : 32'h34);
      pos <= tp[i];
      u_probe.pulse(0, 1'b0, 1'b1, 375);
      rc(OFF_POS, wp[i]);
      rc(OFF_STAT, (i == 0 || i == 2 || i == 4) ? 32'h401 : 32'h402);
      if (i == 1 || i == 3 || i > 4)
        rc(OFF_CAP0, wp[i]);
    end
  endtask

  task automatic t_fault();
    arm(32'h0);
    rc(OFF_STAT, 32'h20000, 32'h30000);
    rc(OFF_FAULT, {16'h0, FC_BAD_SEL});
    virt <= 1'b1;
    arm(32'h4);
    rc(OFF_STAT, 32'h20000, 32'h30001);
    rc(OFF_FAULT, {16'h0, FC_NO_ENC});
    enc <= 1'b1;
    pos <= 32'd42;
    arm(32'h4);
    rc(OFF_FAULT, {16'h0, FC_NONE});
    u_probe.pulse(0, 1'b0, 1'b1, 375);
    rc(OFF_CAP0, 32'd42);
    virt <= 1'b0;
    wr(OFF_WIN_LO, 32'd300);
    wr(OFF_WIN_HI, 32'd200);
    arm(32'h14);
    rc(OFF_STAT, 32'h10001, 32'h30001);
    rc(OFF_FAULT, {16'h0, FC_BAD_WIN});
  endtask

  // Reset, then the scenarios in turn
  initial
  begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_basic();
    t_fall();
    t_remote();
    t_window();
    t_fault();
    report_and_stop();
  end
endmodule // axis_probe_position_capture_tb_top
`default_nettype wire
